// [serial_ctl_dev.sv]
// Implementation choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Functional notes
// (R1) Baud control bit 0 starts baud generator
// (R2) Receive control bit 0 enables receiver
// (R3) Transmit control bit 3 enables transmitter
// (R4) Host rewrites other bits unchanged
// (R5) All-char mode interrupts every char, special
// (R6) Interrupt output needs master enable bit 3
// (R7) No tx interrupt before first char shifts
// (R8) Command 28H clears tx pending flag
// (R9) No tx interrupt until next character
// (R10) Vector read shows highest pending interrupt
// (R11) Next read shows next pending after clear
// (R12) Vector bit 4 tx, bit 5 rx
// (R13) Special status nonzero on char errors
// (R14) Command 30H clears latched errors
// (R15) Host spaces accesses 6, after reset 11
// (R16) Writing C0 to master control resets
// (R17) Interrupt held until all pending cleared
module serial_ctl_dev (
   input  wire logic       core_clk,
   input  wire logic       rst,
   serial_ctl_if.dev       bus,
   input  wire logic       rxValid,
   input  wire logic [7:0] rxChar,
   input  wire logic [2:0] rxErr,
   input  wire logic       txShiftDone,
   output logic            baudEn,
   output logic            rxEn,
   output logic            txEn,
   output logic            txLoad,
   output logic [7:0]      txChar
);
   logic [7:0] baudCtl_ff, rxCtl_ff, txCtl_ff, intMode_ff, mic_ff, vec_ff;
   logic [7:0] rxBuf_ff, spStat_ff, rdData_ff;
   logic       txIp_ff, rxIp_ff, spIp_ff, txBusy_ff, txEmpty_ff, rxAvail_ff;
   logic       intReq_ff, softRst_ff;
   logic       rstAll, wrCmd, rxMode, txIe, rdRx;
   logic [7:0] nxt_vec;

   assign rstAll = rst | softRst_ff;
   assign wrCmd  = bus.wrStb & (bus.regAddr == serial_ctl_pkg::REG_CMD);
   // Reading the data register consumes the received character
   assign rdRx   = bus.rdStb & (bus.regAddr == serial_ctl_pkg::RD_DATA);
   assign rxMode = intMode_ff[serial_ctl_pkg::RX_MODE_LSB +: 2]
                   == serial_ctl_pkg::RX_MODE_ALL;
   assign txIe   = intMode_ff[serial_ctl_pkg::TX_INT_EN_BIT];

   // Bit positions must land inside the byte-wide registers
   if (serial_ctl_pkg::RX_MODE_LSB > 6 || serial_ctl_pkg::MIE_BIT > 7
       || serial_ctl_pkg::TX_EN_BIT > 7 || serial_ctl_pkg::VEC_SP_BIT > 7) begin
      $error("register field position outside the byte");
   end

   // Forced reset acts one cycle after its write, like the pin
   always_ff @(posedge core_clk) begin
      softRst_ff <= ~rst & bus.wrStb
         & (bus.regAddr == serial_ctl_pkg::REG_MASTER_INT)
         & (bus.wrData == serial_ctl_pkg::MIC_FORCE_RESET); // [R16]
   end

   // Control registers take whole bytes as written
   always_ff @(posedge core_clk) begin
      if (rstAll) begin // [R16]
         baudCtl_ff <= 8'h00;
         rxCtl_ff   <= 8'h00;
         txCtl_ff   <= 8'h00;
         intMode_ff <= 8'h00;
         mic_ff     <= 8'h00;
         vec_ff     <= 8'h00;
      end else if (bus.wrStb) begin
         unique case (bus.regAddr)
            serial_ctl_pkg::REG_BAUD_CTL:   baudCtl_ff <= bus.wrData;
            serial_ctl_pkg::REG_RX_CTL:     rxCtl_ff   <= bus.wrData;
            serial_ctl_pkg::REG_TX_CTL:     txCtl_ff   <= bus.wrData;
            serial_ctl_pkg::REG_INT_MODE:   intMode_ff <= bus.wrData;
            serial_ctl_pkg::REG_MASTER_INT: mic_ff     <= bus.wrData;
            serial_ctl_pkg::REG_VECTOR:     vec_ff     <= bus.wrData;
            default: ;
         endcase
      end
   end

   // Enables follow their control bits one cycle later
   always_ff @(posedge core_clk) begin
      baudEn <= ~rstAll & baudCtl_ff[serial_ctl_pkg::BAUD_EN_BIT]; // [R1]
      rxEn   <= ~rstAll & rxCtl_ff[serial_ctl_pkg::RX_EN_BIT];     // [R2]
      txEn   <= ~rstAll & txCtl_ff[serial_ctl_pkg::TX_EN_BIT];     // [R3]
   end

   // Transmit path: buffer to shift register
   // A data write with the transmitter off is dropped
   always_ff @(posedge core_clk) begin
      if (rstAll) begin
         txLoad     <= 1'b0;
         txChar     <= 8'h00;
         txBusy_ff  <= 1'b0;
         txEmpty_ff <= 1'b1;
      end else begin
         txLoad <= 1'b0;
         if (bus.wrStb && bus.regAddr == serial_ctl_pkg::WR_DATA && txEn) begin
            txChar <= bus.wrData;
            txLoad <= 1'b1;
            txBusy_ff <= 1'b1;
         end else if (txShiftDone) begin
            txBusy_ff <= 1'b0;
         end
         txEmpty_ff <= ~txBusy_ff;
      end
   end

   // Transmit pending: set when a written char enters the shifter
   // Set wins, so a load racing a clear is never lost
   always_ff @(posedge core_clk) begin
      if (rstAll) begin
         txIp_ff <= 1'b0;
      end else if (txLoad && txIe) begin
         txIp_ff <= 1'b1; // [R7] [R9]
      end else if (wrCmd && bus.wrData == serial_ctl_pkg::CMD_RESET_TX_IP) begin
         txIp_ff <= 1'b0; // [R8]
      end else if (bus.wrStb && bus.regAddr == serial_ctl_pkg::WR_DATA) begin
         txIp_ff <= 1'b0;
      end
   end

   // Receive character
   always_ff @(posedge core_clk) begin
      if (rstAll) begin
         rxBuf_ff   <= 8'h00;
         rxAvail_ff <= 1'b0;
         rxIp_ff    <= 1'b0;
      end else if (rxValid && rxEn) begin
         rxBuf_ff   <= rxChar;
         rxAvail_ff <= 1'b1;
         rxIp_ff    <= rxMode; // [R5]
      end else if (rdRx) begin
         rxAvail_ff <= 1'b0;
         rxIp_ff    <= 1'b0;
      end
   end

   // Special condition: sticky; an error in the clear cycle still latches
   always_ff @(posedge core_clk) begin
      if (rstAll) begin
         spStat_ff <= 8'h00;
         spIp_ff   <= 1'b0;
      end else begin
         if (wrCmd && bus.wrData == serial_ctl_pkg::CMD_ERROR_RESET) begin
            spStat_ff <= 8'h00; // [R14]
            spIp_ff   <= 1'b0;  // [R14]
         end
         if (rxValid && rxEn) begin
            if (rxErr[2] || (rxAvail_ff && !rdRx))
               spStat_ff[serial_ctl_pkg::ERR_OVERRUN] <= 1'b1; // [R13]
            if (rxErr[0])
               spStat_ff[serial_ctl_pkg::ERR_PARITY] <= 1'b1;  // [R13]
            if (rxErr[1])
               spStat_ff[serial_ctl_pkg::ERR_FRAMING] <= 1'b1; // [R13]
            if (rxMode && ((|rxErr) || (rxAvail_ff && !rdRx)))
               spIp_ff <= 1'b1;                                // [R5]
         end
      end
   end

   // Status-bearing vector: special > rx > tx
   // Status bits are rebuilt for each read, never stored
   always_comb begin
      nxt_vec = vec_ff;
      nxt_vec[serial_ctl_pkg::VEC_TX_BIT] = 1'b0;
      nxt_vec[serial_ctl_pkg::VEC_RX_BIT] = 1'b0;
      nxt_vec[serial_ctl_pkg::VEC_SP_BIT] = 1'b0;
      if (spIp_ff) begin
         nxt_vec[serial_ctl_pkg::VEC_SP_BIT] = 1'b1; // [R10]
         nxt_vec[serial_ctl_pkg::VEC_RX_BIT] = 1'b1;
      end else if (rxIp_ff) begin
         nxt_vec[serial_ctl_pkg::VEC_RX_BIT] = 1'b1; // [R11] [R12]
      end else if (txIp_ff) begin
         nxt_vec[serial_ctl_pkg::VEC_TX_BIT] = 1'b1; // [R11] [R12]
      end
   end

   // Read data stands from the edge after the read strobe
   always_ff @(posedge core_clk) begin
      if (rstAll) begin
         rdData_ff <= 8'h00;
      end else if (bus.rdStb) begin
         unique case (bus.regAddr)
            serial_ctl_pkg::RD_VECTOR:     rdData_ff <= nxt_vec; // [R10]
            serial_ctl_pkg::RD_SPECIAL:    rdData_ff <= spStat_ff; // [R13]
            // Buffer status: bit 2 transmit empty, bit 0 receive full
            serial_ctl_pkg::RD_BUF_STATUS:
               rdData_ff <= {5'h00, txEmpty_ff, 1'b0, rxAvail_ff};
            serial_ctl_pkg::RD_DATA:       rdData_ff <= rxBuf_ff;
            default:                       rdData_ff <= 8'h00;
         endcase
      end
   end
   assign bus.rdData = rdData_ff;

   // Registered so the interrupt pin never glitches
   always_ff @(posedge core_clk) begin
      if (rstAll)
         intReq_ff <= 1'b0;
      else
         intReq_ff <= mic_ff[serial_ctl_pkg::MIE_BIT]
                      & (txIp_ff | rxIp_ff | spIp_ff); // [R6] [R17]
   end
   assign bus.intReq = intReq_ff;
endmodule

// [serial_ctl_pkg.sv]
package serial_ctl_pkg;
   localparam logic [3:0] REG_CMD        = 4'h0;
   localparam logic [3:0] REG_INT_MODE   = 4'h1;
   localparam logic [3:0] REG_VECTOR     = 4'h2;
   localparam logic [3:0] REG_RX_CTL     = 4'h3;
   localparam logic [3:0] REG_TX_CTL     = 4'h5;
   localparam logic [3:0] REG_MASTER_INT = 4'h9;
   localparam logic [3:0] REG_BAUD_CTL   = 4'hE;
   localparam logic [3:0] RD_BUF_STATUS  = 4'h0;
   localparam logic [3:0] RD_SPECIAL     = 4'h1;
   localparam logic [3:0] RD_VECTOR      = 4'h2;
   localparam logic [3:0] RD_DATA        = 4'h8;
   localparam logic [3:0] WR_DATA        = 4'h8;
   localparam int BAUD_EN_BIT   = 0;
   localparam int RX_EN_BIT     = 0;
   localparam int TX_EN_BIT     = 3;
   localparam int MIE_BIT       = 3;
   localparam int TX_INT_EN_BIT = 1;
   localparam int RX_MODE_LSB   = 3;
   localparam int VEC_TX_BIT    = 4;
   localparam int VEC_RX_BIT    = 5;
   localparam int VEC_SP_BIT    = 6;
   localparam int ERR_PARITY    = 4;
   localparam int ERR_OVERRUN   = 5;
   localparam int ERR_FRAMING   = 6;
   localparam logic [1:0] RX_MODE_ALL = 2'h2;
   localparam logic [7:0] CMD_RESET_TX_IP = 8'h28;
   localparam logic [7:0] CMD_ERROR_RESET = 8'h30;
   localparam logic [7:0] MIC_FORCE_RESET = 8'hC0;
   localparam int CYCLE_RECOVERY = 6;
   localparam int RESET_RECOVERY = 11;
   // Host side registers over AHB-Lite (byte addresses)
   localparam logic [7:0] H_CTRL   = 8'h00;
   localparam logic [7:0] H_WDATA  = 8'h04;
   localparam logic [7:0] H_RDATA  = 8'h08;
   localparam logic [7:0] H_STATUS = 8'h0C;
   localparam logic [7:0] H_IRQ_ST = 8'h10;
   localparam logic [7:0] H_IRQ_MK = 8'h14;
   localparam int H_BUSY_BIT = 0;
   localparam int H_INT_BIT  = 1;
   localparam logic [1:0] IRQ_RESET = 2'h0;
endpackage

// [serial_ctl_if.sv]
`timescale 1ns/1ns
interface serial_ctl_if;
   logic       wrStb;
   logic       rdStb;
   logic [3:0] regAddr;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic       intReq;
   modport dev (input wrStb, input rdStb, input regAddr, input wrData,
                output rdData, output intReq);
   modport host (output wrStb, output rdStb, output regAddr,
                 output wrData, input rdData, input intReq);
endinterface

// [serial_ctl_host.sv]
`timescale 1ns/1ns
module serial_ctl_host (
   input  wire logic        core_clk,
   input  wire logic        rst,
   serial_ctl_if.host       link,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq
);
   logic        aWr_ff, aRd_ff;
   logic [7:0]  aAddr_ff;
   logic [3:0]  gap_ff;
   logic        pend_ff, pendWr_ff;
   logic [11:0] pendCmd_ff;
   logic [7:0]  rdData_ff;
   logic [1:0]  irqSt_ff, irqMk_ff;
   logic        intSeen_ff, busy;
   logic        wrStb_ff, rdStb_ff, rdCap_ff;
   logic [3:0]  regAddr_ff;
   logic [7:0]  wrData_ff;
   logic        issue, rdDone;

   assign busy  = pend_ff | (gap_ff != 4'h0);
   assign issue = pend_ff & (gap_ff == 4'h0);
   assign rdDone = rdCap_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         aWr_ff <= 1'b0;
         aRd_ff <= 1'b0;
         aAddr_ff <= 8'h00;
      end else if (hready) begin
         aWr_ff <= hsel & htrans[1] & hwrite;
         aRd_ff <= hsel & htrans[1] & ~hwrite;
         aAddr_ff <= haddr[7:0];
      end
   end

   always_ff @(posedge core_clk) begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      if (rst)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite)
         unique case (haddr[7:0])
            serial_ctl_pkg::H_RDATA:  hrdata <= {24'h000000, rdData_ff};
            serial_ctl_pkg::H_STATUS: hrdata <= {30'h0, intSeen_ff, busy};
            serial_ctl_pkg::H_IRQ_ST: hrdata <= {30'h0, irqSt_ff};
            serial_ctl_pkg::H_IRQ_MK: hrdata <= {30'h0, irqMk_ff};
            default:                  hrdata <= 32'h0000_0000;
         endcase
   end

   // Command posting: WDATA holds addr[11:8] and data[7:0] for a write; CTRL bits 3:0 post a read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_ff    <= 1'b0;
         pendWr_ff  <= 1'b0;
         pendCmd_ff <= 12'h000;
      end else if (aWr_ff && aAddr_ff == serial_ctl_pkg::H_WDATA && !busy) begin
         pend_ff    <= 1'b1;
         pendWr_ff  <= 1'b1;
         pendCmd_ff <= hwdata[11:0];
      end else if (aWr_ff && aAddr_ff == serial_ctl_pkg::H_CTRL && !busy) begin
         pend_ff    <= 1'b1;
         pendWr_ff  <= 1'b0;
         pendCmd_ff <= {hwdata[3:0], 8'h00};
      end else if (issue) begin
         pend_ff <= 1'b0;
      end
   end

   // Recovery spacing between device accesses
   always_ff @(posedge core_clk) begin
      if (rst) begin
         gap_ff <= 4'(serial_ctl_pkg::RESET_RECOVERY); // [R15]
      end else if (issue) begin
         gap_ff <= (pendWr_ff
            && pendCmd_ff[11:8] == serial_ctl_pkg::REG_MASTER_INT
            && pendCmd_ff[7:0] == serial_ctl_pkg::MIC_FORCE_RESET)
            ? 4'(serial_ctl_pkg::RESET_RECOVERY)
            : 4'(serial_ctl_pkg::CYCLE_RECOVERY); // [R15]
      end else if (gap_ff != 4'h0) begin
         gap_ff <= gap_ff - 4'h1;
      end
   end

   // Strobes to the device, whole-byte writes as given
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wrStb_ff   <= 1'b0;
         rdStb_ff   <= 1'b0;
         rdCap_ff   <= 1'b0;
         regAddr_ff <= 4'h0;
         wrData_ff  <= 8'h00;
         rdData_ff  <= 8'h00;
      end else begin
         wrStb_ff <= issue & pendWr_ff; // [R4]
         rdStb_ff <= issue & ~pendWr_ff;
         rdCap_ff <= rdStb_ff;
         if (issue) begin
            regAddr_ff <= pendCmd_ff[11:8];
            wrData_ff  <= pendCmd_ff[7:0]; // [R1] [R2] [R3] [R8] [R14]
         end
         if (rdDone)
            rdData_ff <= link.rdData;
      end
   end
   assign link.wrStb   = wrStb_ff;
   assign link.rdStb   = rdStb_ff;
   assign link.regAddr = regAddr_ff;
   assign link.wrData  = wrData_ff;

   // Interrupt status: bit0 device int rose, bit1 read done
   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqSt_ff   <= serial_ctl_pkg::IRQ_RESET;
         irqMk_ff   <= serial_ctl_pkg::IRQ_RESET;
         intSeen_ff <= 1'b0;
         irq        <= 1'b0;
      end else begin
         intSeen_ff <= link.intReq;
         if (aWr_ff && aAddr_ff == serial_ctl_pkg::H_IRQ_ST)
            irqSt_ff <= irqSt_ff & ~hwdata[1:0]
                        | {rdDone, link.intReq & ~intSeen_ff};
         else
            irqSt_ff <= irqSt_ff | {rdDone, link.intReq & ~intSeen_ff};
         if (aWr_ff && aAddr_ff == serial_ctl_pkg::H_IRQ_MK)
            irqMk_ff <= hwdata[1:0];
         irq <= |(irqSt_ff & irqMk_ff);
      end
   end
endmodule

// [serial_ctl_asserts.sv]
`timescale 1ns/1ns
module serial_ctl_asserts (
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       wrStb,
   input wire logic       rdStb,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic       intReq
);
   logic       mieFf, longFf, anyStb, forceRst, vecRd, mieWr;
   logic [3:0] gapFf;
   assign anyStb = wrStb | rdStb;
   assign vecRd = rdStb && regAddr == serial_ctl_pkg::RD_VECTOR;
   assign mieWr = wrStb && regAddr == serial_ctl_pkg::REG_MASTER_INT;
   assign forceRst = mieWr && wrData == serial_ctl_pkg::MIC_FORCE_RESET;
   always_ff @(posedge core_clk) begin
      if (rst)
         mieFf <= 1'b0;
      else if (mieWr)
         mieFf <= wrData[serial_ctl_pkg::MIE_BIT];
   end
   // Cycles since the last strobe, saturating
   always_ff @(posedge core_clk) begin
      if (rst || anyStb)
         gapFf <= 4'h1;
      else if (gapFf != 4'hF)
         gapFf <= gapFf + 4'h1;
   end
   // Long recovery owed after either kind of reset
   always_ff @(posedge core_clk) begin
      if (rst)
         longFf <= 1'b1;
      else if (anyStb)
         longFf <= forceRst;
   end
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence noStb; !anyStb [*5]; endsequence
   sequence quietInt; !intReq [*4]; endsequence
   cycle_gap_a: assert property (anyStb |=> noStb)
      else $error("strobes too close");
   reset_gap_a: assert property (
      anyStb |-> gapFf >= (longFf ? 4'hB : 4'h6))
      else $error("recovery gap too short");
   strobe_excl_a: assert property (!(wrStb && rdStb))
      else $error("read and write together");
   mie_off_a: assert property (
      !mieFf && !$past(mieFf) && !$past(mieFf, 2) |-> !intReq)
      else $error("interrupt without master enable");
   mie_rise_a: assert property (
      $rose(intReq) |-> mieFf || $past(mieFf))
      else $error("interrupt rose with enable off");
   force_rst_a: assert property (forceRst |-> ##[1:4] quietInt)
      else $error("interrupt survived forced reset");
   int_drop_a: assert property ($fell(intReq) |->
      $past(anyStb) || $past(anyStb, 2) || $past(anyStb, 3)
      || $past(anyStb, 4))
      else $error("interrupt dropped with no access");
   vec_live_a: assert property (
      vecRd && intReq |=> rdData[6:4] != 3'h0)
      else $error("vector shows nothing pending");
   vec_code_a: assert property (vecRd |=>
      rdData[6:4] inside {3'h0, 3'h1, 3'h2, 3'h6})
      else $error("illegal vector status");
endmodule

// [tb_serial_async_enable_interrupt_ctl.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module tb_serial_async_enable_interrupt_ctl;
   logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, rxErr = 3'h0;
   logic        hreadyout, hresp, irq, rxValid = 1'b0;
   logic [7:0]  rxChar = 8'h0, txChar, lastTx, v;
   logic        txShiftDone = 1'b0, baudEn, rxEn, txEn, txLoad;
   logic [31:0] s;
   int          errors = 0, tests_run = 0, loadCnt = 0;
   serial_ctl_if link ();
   serial_ctl_dev serial_ctl_dev_inst (.core_clk(core_clk), .rst(rst),
      .bus(link), .rxValid(rxValid), .rxChar(rxChar), .rxErr(rxErr),
      .txShiftDone(txShiftDone), .baudEn(baudEn), .rxEn(rxEn),
      .txEn(txEn), .txLoad(txLoad), .txChar(txChar));
   serial_ctl_host serial_ctl_host_inst (.core_clk(core_clk), .rst(rst),
      .link(link), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   serial_ctl_asserts serial_ctl_asserts_inst (.core_clk(core_clk),
      .rst(rst), .wrStb(link.wrStb), .rdStb(link.rdStb),
      .regAddr(link.regAddr), .wrData(link.wrData),
      .rdData(link.rdData), .intReq(link.intReq));
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (txLoad === 1'b1) begin
         loadCnt <= loadCnt + 1;
         lastTx <= txChar;
      end
   end
   // Samples hready at the edge, before the slave's update lands
   task automatic waitRdy;
      do begin
         @(posedge core_clk);
      end while (hreadyout !== 1'b1);
   endtask
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic e);
      logic [31:0] q;
      int n;
      n = 0;
      do begin
         ahb(1'b0, a, 32'h0, q);
         n++;
      end while (q[b] !== e && n < 200);
      `CHK(q[b], e)
   endtask
   task automatic devWr(input logic [3:0] r, input logic [7:0] d);
      poll(serial_ctl_pkg::H_STATUS, serial_ctl_pkg::H_BUSY_BIT, 1'b0);
      wr(serial_ctl_pkg::H_WDATA, {20'h0, r, d});
      poll(serial_ctl_pkg::H_STATUS, serial_ctl_pkg::H_BUSY_BIT, 1'b0);
   endtask
   task automatic devRd(input logic [3:0] r);
      poll(serial_ctl_pkg::H_STATUS, serial_ctl_pkg::H_BUSY_BIT, 1'b0);
      wr(serial_ctl_pkg::H_IRQ_ST, 32'h2);
      wr(serial_ctl_pkg::H_CTRL, {28'h0, r});
      poll(serial_ctl_pkg::H_IRQ_ST, 1, 1'b1);
      ahb(1'b0, serial_ctl_pkg::H_RDATA, 32'h0, s);
      v = s[7:0];
   endtask
   task automatic intIs(input logic e);
      poll(serial_ctl_pkg::H_STATUS, serial_ctl_pkg::H_INT_BIT, e);
   endtask
   task automatic vecIs(input logic [7:0] e);
      devRd(serial_ctl_pkg::RD_VECTOR);
      `CHK(v, e)
   endtask
   task automatic rxPulse(input logic [7:0] c, input logic [2:0] e);
      @(posedge core_clk);
      rxValid <= 1'b1;
      rxChar <= c;
      rxErr <= e;
      @(posedge core_clk);
      rxValid <= 1'b0;
      rxChar <= ~c;
   endtask
   task automatic tEnable;
      logic [3:0] r [3];
      logic [7:0] b [3];
      logic [7:0] e [3];
      r = '{serial_ctl_pkg::REG_BAUD_CTL, serial_ctl_pkg::REG_RX_CTL,
            serial_ctl_pkg::REG_TX_CTL};
      b = '{8'h10, 8'hC0, 8'h60};
      e = '{8'h11, 8'hC1, 8'h68};
      for (int i = 0; i < 3; i++) begin
         devWr(r[i], b[i]);
         `CHK({baudEn, rxEn, txEn}, 3'(3'h7 << (3 - i)))
         devWr(r[i], e[i]);
         `CHK({baudEn, rxEn, txEn}, 3'(3'h7 << (2 - i)))
      end
      $display("enable test done");
   endtask
   task automatic tTx;
      devWr(serial_ctl_pkg::REG_INT_MODE, 8'h12);
      devWr(serial_ctl_pkg::REG_MASTER_INT, 8'h08);
      wr(serial_ctl_pkg::H_IRQ_ST, 32'h3);
      wr(serial_ctl_pkg::H_IRQ_MK, 32'h1);
      intIs(1'b0);
      `CHK(loadCnt, 0)
      devWr(serial_ctl_pkg::WR_DATA, 8'hA5);
      @(posedge core_clk);
      txShiftDone <= 1'b1;
      @(posedge core_clk);
      txShiftDone <= 1'b0;
      `CHK(lastTx, 8'hA5)
      vecIs(8'h10);
      intIs(1'b1);
      `CHK(irq, 1'b1)
      wr(serial_ctl_pkg::H_IRQ_MK, 32'h0);
      ahb(1'b0, serial_ctl_pkg::H_IRQ_ST, 32'h0, s);
      `CHK(s[0], 1'b1)
      `CHK(irq, 1'b0)
      wr(serial_ctl_pkg::H_IRQ_ST, 32'h1);
      ahb(1'b0, serial_ctl_pkg::H_IRQ_ST, 32'h0, s);
      `CHK(s[0], 1'b0)
      devWr(serial_ctl_pkg::REG_CMD, serial_ctl_pkg::CMD_RESET_TX_IP);
      intIs(1'b0);
      vecIs(8'h00);
      intIs(1'b0);
      $display("transmit test done");
   endtask
   task automatic tRx;
      devWr(serial_ctl_pkg::WR_DATA, 8'h5A);
      rxPulse(8'h3C, 3'h0);
      vecIs(8'h20);
      devRd(serial_ctl_pkg::RD_BUF_STATUS);
      `CHK(v, 8'h01)
      devRd(serial_ctl_pkg::RD_DATA);
      `CHK(v, 8'h3C)
      vecIs(8'h10);
      devWr(serial_ctl_pkg::REG_CMD, serial_ctl_pkg::CMD_RESET_TX_IP);
      intIs(1'b0);
      `CHK(lastTx, 8'h5A)
      $display("receive test done");
   endtask
   task automatic tErr;
      logic [2:0] ex [3];
      ex = '{3'h1, 3'h4, 3'h2};
      devWr(serial_ctl_pkg::REG_MASTER_INT, 8'h00);
      for (int i = 0; i < 3; i++) begin
         rxPulse(8'hC3, 3'(1 << i));
         if (i == 0) begin
            intIs(1'b0);
            devWr(serial_ctl_pkg::REG_MASTER_INT, 8'h08);
            intIs(1'b1);
            vecIs(8'h60);
         end
         devRd(serial_ctl_pkg::RD_SPECIAL);
         `CHK(v[6:4], ex[i])
         devRd(serial_ctl_pkg::RD_DATA);
         `CHK(v, 8'hC3)
         devWr(serial_ctl_pkg::REG_CMD, serial_ctl_pkg::CMD_ERROR_RESET);
         devRd(serial_ctl_pkg::RD_SPECIAL);
         `CHK(v[6:4], 3'h0)
      end
      intIs(1'b0);
      $display("error test done");
   endtask
   task automatic tReset;
      devWr(serial_ctl_pkg::REG_MASTER_INT, serial_ctl_pkg::MIC_FORCE_RESET);
      `CHK({baudEn, rxEn, txEn}, 3'h0)
      devWr(serial_ctl_pkg::REG_BAUD_CTL, 8'h11);
      `CHK(baudEn, 1'b1)
      devWr(serial_ctl_pkg::REG_VECTOR, 8'h81);
      vecIs(8'h81);
      ahb(1'b0, 8'h3C, 32'h0, s);
      `CHK(hresp, 1'b0)
      $display("reset test done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      tEnable();
      tTx();
      tRx();
      tErr();
      tReset();
      results();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      results();
   end
endmodule
